/* tsu_top.sv */
// Trigger synchronisation unit: input conditioning, functions and output line
`timescale 1ns/1ps
`default_nettype none
module tsu_top #(
   parameter int unsigned SAMPLE_DIV = tsu_pkg::SAMPLE_DIV, // Cycles per 400 Hz sample
   parameter int unsigned REF_DIV    = tsu_pkg::REF_DIV     // Cycles per 1 Hz period
) (
   input  wire logic                    clk_i,               // 200 MHz clock
   input  wire logic                    srst_i,              // Sync reset, active high
   input  wire logic [tsu_pkg::N_IN_LINE-1:0] trigger_input_line_i, // Async pins
   input  wire logic                    software_request_line_i, // Software trigger pulse
   input  wire logic                    cfg_write_i,         // Load new config set
   input  wire tsu_pkg::tsu_entry_t [tsu_pkg::N_ENTRY-1:0] trigger_config_set_i, // Entries
   input  wire tsu_pkg::tsu_out_cfg_t   out_cfg_i,           // Output line config
   input  wire logic                    meas_mode_enter_i,   // New measurement mode pulse
   output logic                         trigger_output_line_o, // Output pin
   output logic                         sample_tick_o,       // 400 Hz sample pulse
   output logic                         data_out_strobe_o,   // Emit output record pulse
   output logic                         trigger_marker_flag_o, // Status word marker
   output tsu_pkg::tsu_msg_t            trigger_msg_o,       // Timestamped marker message
   output logic                         stream_active_o,     // Output streaming level
   output logic [tsu_pkg::N_ENTRY-1:0]  cfg_reject_o         // Entries refused
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [tsu_pkg::N_IN_LINE-1:0]       sync1;
      logic [tsu_pkg::N_IN_LINE-1:0]       sync2;
      tsu_pkg::tsu_entry_t [tsu_pkg::N_ENTRY-1:0] cfg;
      tsu_pkg::tsu_out_cfg_t               ocfg;
      logic [tsu_pkg::N_ENTRY-1:0]         act;
      logic                                restart;
      logic [tsu_pkg::CNT_W-1:0]           sdiv;
      logic [tsu_pkg::CNT_W-1:0]           rdiv;
      logic [tsu_pkg::CNT_W-1:0]           stamp;
      logic                                tick;
      logic                                strobe;
      logic                                marker;
      tsu_pkg::tsu_msg_t                   msg;
      logic                                streaming;
      logic                                out_start;
   } tsu_st_t;

   tsu_st_t                      st_q;
   tsu_st_t                      st_d;
   logic [tsu_pkg::N_ENTRY-1:0]  accept;
   logic [tsu_pkg::N_ENTRY-1:0]  act_new;
   logic                         out_pulse;

   // ****************************************************************
   // Configuration checks
   // ****************************************************************
   function automatic logic is_input(input tsu_pkg::tsu_line_t l);
      return (l == tsu_pkg::LINE_IN1) || (l == tsu_pkg::LINE_IN2);
   endfunction : is_input

   function automatic logic is_exclusive(input tsu_pkg::tsu_func_t f);
      return (f == tsu_pkg::FN_LATEST) || (f == tsu_pkg::FN_START);
   endfunction : is_exclusive

   // Decides whether entry idx may run alongside the others; lower index wins between exclusive functions, a clock-lock line clash refuses both
   function automatic logic entry_ok(
      input tsu_pkg::tsu_entry_t [tsu_pkg::N_ENTRY-1:0] c,
      input int unsigned                                idx
   );
      logic ok;
      ok = c[idx].enable && (c[idx].func != tsu_pkg::FN_NONE);
      // No function may use the output line; an entry on it is always refused
      if (c[idx].line == tsu_pkg::LINE_OUT) begin
         ok = 1'b0;
      end
      if (c[idx].func == tsu_pkg::FN_CLOCK_LOCK && !is_input(c[idx].line)) begin
         ok = 1'b0;
      end
      for (int unsigned j = 0; j < tsu_pkg::N_ENTRY; j++) begin
         if (j != idx && c[j].enable && c[j].line == c[idx].line && is_input(c[idx].line)) begin
            if (c[j].func == tsu_pkg::FN_CLOCK_LOCK || c[idx].func == tsu_pkg::FN_CLOCK_LOCK) begin
               ok = 1'b0;
            end
         end
         if (j < idx && c[j].enable && is_exclusive(c[j].func) && is_exclusive(c[idx].func)) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : entry_ok

   // ****************************************************************
   // Per-entry trigger qualifiers
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < tsu_pkg::N_ENTRY; gi++) begin : g_entry
         logic lvl;
         // Each entry taps its own line, so one function on both lines is two entries
         assign lvl = (st_q.cfg[gi].line == tsu_pkg::LINE_IN2) ? st_q.sync2[1] :
                      st_q.sync2[0];
         assign act_new[gi] = entry_ok(trigger_config_set_i, gi);

         tsu_trig_qual u_qual (
            .clk_i     (clk_i),
            .srst_i    (srst_i),
            .restart_i (st_q.restart),
            .cfg_i     (st_q.cfg[gi]),
            .active_i  (st_q.act[gi]),
            .lvl_i     (lvl),
            .sw_req_i  (software_request_line_i),
            .accept_o  (accept[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // Function logic
   // ****************************************************************
   always_comb begin
      logic mark_any;
      logic msg_any;
      logic latest_any;
      logic start_any;
      logic lock_any;
      logic latest_mode;
      mark_any    = 1'b0;
      msg_any     = 1'b0;
      latest_any  = 1'b0;
      start_any   = 1'b0;
      lock_any    = 1'b0;
      latest_mode = 1'b0;
      st_d        = st_q;
      st_d.sync1  = trigger_input_line_i;
      st_d.sync2  = st_q.sync1;
      st_d.restart = cfg_write_i | meas_mode_enter_i;
      st_d.tick      = 1'b0;
      st_d.strobe    = 1'b0;
      st_d.out_start = 1'b0;
      st_d.msg.valid = 1'b0;
      st_d.stamp     = st_q.stamp + tsu_pkg::CNT_W'(1);

      if (cfg_write_i) begin
         st_d.cfg  = trigger_config_set_i;
         st_d.ocfg = out_cfg_i;
         st_d.act  = act_new;
      end

      for (int unsigned i = 0; i < tsu_pkg::N_ENTRY; i++) begin
         if (st_q.act[i]) begin
            case (st_q.cfg[i].func)
               tsu_pkg::FN_MARK: begin
                  mark_any = mark_any | accept[i];
                  msg_any  = msg_any | (accept[i] & st_q.cfg[i].msg_en);
               end
               tsu_pkg::FN_LATEST: begin
                  latest_mode = 1'b1;
                  latest_any  = latest_any | accept[i];
               end
               tsu_pkg::FN_START: begin
                  start_any = start_any | accept[i];
               end
               tsu_pkg::FN_CLOCK_LOCK: begin
                  lock_any = lock_any | accept[i];
               end
               default: begin
               end
            endcase
         end
      end

      // Sample clock; the reference edge restarts the phase so drift never accumulates
      if (lock_any || start_any || st_q.sdiv >= tsu_pkg::CNT_W'(SAMPLE_DIV - 1)) begin
         st_d.sdiv = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.sdiv = st_q.sdiv + tsu_pkg::CNT_W'(1);
      end
      if (lock_any || st_q.rdiv >= tsu_pkg::CNT_W'(REF_DIV - 1)) begin
         st_d.rdiv = '0;
      end else begin
         st_d.rdiv = st_q.rdiv + tsu_pkg::CNT_W'(1);
      end

      // Start mode holds streaming off until its trigger; other modes stream freely
      if (meas_mode_enter_i || cfg_write_i) begin
         st_d.streaming = 1'b1;
         for (int unsigned i = 0; i < tsu_pkg::N_ENTRY; i++) begin
            if (act_new[i] && trigger_config_set_i[i].func == tsu_pkg::FN_START) begin
               st_d.streaming = 1'b0;
            end
         end
      end else if (start_any) begin
         st_d.streaming = 1'b1;
      end

      if (latest_mode) begin
         st_d.strobe = latest_any;
      end else begin
         st_d.strobe = st_d.tick && (st_q.streaming || start_any);
      end

      // Marker covers one output record; a new mark on the strobe cycle survives
      if (mark_any) begin
         st_d.marker = 1'b1;
      end else if (st_q.strobe) begin
         st_d.marker = 1'b0;
      end
      if (msg_any) begin
         st_d.msg.valid = 1'b1;
         st_d.msg.stamp = st_q.stamp;
      end

      case (st_q.ocfg.mode)
         tsu_pkg::OUT_SAMPLE_TICK: st_d.out_start = st_d.tick;
         tsu_pkg::OUT_REF_1HZ:     st_d.out_start = (st_d.rdiv == '0);
         default:                  st_d.out_start = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q           <= '0;
         st_q.streaming <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // Output line
   // ****************************************************************
   tsu_pulse_gen u_pulse (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .start_i    (st_q.out_start),
      .width_us_i (st_q.ocfg.pulse_us),
      .pulse_o    (out_pulse)
   );

   assign trigger_output_line_o = out_pulse;
   assign sample_tick_o         = st_q.tick;
   assign data_out_strobe_o     = st_q.strobe;
   assign trigger_marker_flag_o = st_q.marker;
   assign trigger_msg_o         = st_q.msg;
   assign stream_active_o       = st_q.streaming;
   assign cfg_reject_o          = ~st_q.act;

endmodule : tsu_top
`default_nettype wire

/* tsu_pkg.sv */
// Shared constants, types and configuration layout of the trigger synchronisation unit
package tsu_pkg;

   localparam int unsigned CLK_HZ     = 200_000_000;
   localparam int unsigned US_PER_S   = 1_000_000;
   localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
   localparam int unsigned SAMPLE_HZ  = 400;
   localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned REF_HZ     = 1;
   localparam int unsigned REF_DIV    = CLK_HZ / REF_HZ;
   localparam int unsigned N_ENTRY    = 4;
   localparam int unsigned N_IN_LINE  = 2;
   localparam int unsigned CNT_W      = 32;

   typedef enum logic [1:0] {
      LINE_IN1,
      LINE_IN2,
      LINE_SW_REQ,
      LINE_OUT
   } tsu_line_t;

   typedef enum logic [1:0] {
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } tsu_edge_t;

   typedef enum logic [2:0] {
      FN_NONE,
      FN_MARK,
      FN_LATEST,
      FN_START,
      FN_CLOCK_LOCK
   } tsu_func_t;

   typedef enum logic [1:0] {
      OUT_OFF,
      OUT_SAMPLE_TICK,
      OUT_REF_1HZ
   } tsu_out_mode_t;

   typedef struct packed {
      logic          enable;
      tsu_func_t     func;
      tsu_line_t     line;
      tsu_edge_t     edge_sel;
      logic [15:0]   skip_first;
      logic [15:0]   skip_factor;
      logic          once;
      logic          msg_en;
      logic [15:0]   delay_us;
   } tsu_entry_t;

   typedef struct packed {
      tsu_out_mode_t mode;
      logic [15:0]   pulse_us;
   } tsu_out_cfg_t;

   typedef struct packed {
      logic              valid;
      logic [CNT_W-1:0]  stamp;
   } tsu_msg_t;

endpackage : tsu_pkg

/* tsu_trig_qual.sv */
// One input configuration entry: edge detect, skip counts, one-shot and delay
`timescale 1ns/1ps
`default_nettype none
module tsu_trig_qual (
   input  wire logic              clk_i,      // 200 MHz clock
   input  wire logic              srst_i,     // Sync reset, active high
   input  wire logic              restart_i,  // Config rewrite or new mode
   input  wire tsu_pkg::tsu_entry_t cfg_i,    // Entry settings
   input  wire logic              active_i,   // Entry accepted by checks
   input  wire logic              lvl_i,      // Synchronised line level
   input  wire logic              sw_req_i,   // Software request pulse
   output logic                   accept_o    // Accepted trigger pulse
);
   typedef struct packed {
      logic                     prev;
      logic [15:0]              skip_cnt;
      logic [15:0]              phase;
      logic                     done;
      logic                     busy;
      logic [tsu_pkg::CNT_W-1:0] dly;
      logic                     fire;
   } tsu_qual_st_t;

   tsu_qual_st_t st_q;
   tsu_qual_st_t st_d;
   logic         hit;
   logic         rise;
   logic         fall;
   logic [tsu_pkg::CNT_W-1:0] dly_cyc;

   assign dly_cyc = tsu_pkg::CNT_W'(cfg_i.delay_us) * tsu_pkg::CNT_W'(tsu_pkg::CYC_PER_US);

   always_comb begin
      st_d      = st_q;
      st_d.prev = lvl_i;
      st_d.fire = 1'b0;
      rise      = lvl_i & ~st_q.prev;
      fall      = ~lvl_i & st_q.prev;
      case (cfg_i.edge_sel)
         tsu_pkg::EDGE_RISE: hit = rise;
         tsu_pkg::EDGE_FALL: hit = fall;
         tsu_pkg::EDGE_BOTH: hit = rise | fall;
         default:            hit = 1'b0;
      endcase
      if (cfg_i.line == tsu_pkg::LINE_SW_REQ) begin
         hit = sw_req_i;
      end
      hit = hit & active_i;
      if (restart_i) begin
         st_d.skip_cnt = '0;
         st_d.phase    = '0;
         st_d.done     = 1'b0;
         st_d.busy     = 1'b0;
      end else begin
         if (st_q.busy) begin
            if (st_q.dly <= tsu_pkg::CNT_W'(1)) begin
               st_d.busy = 1'b0;
               st_d.fire = 1'b1;
            end else begin
               st_d.dly = st_q.dly - tsu_pkg::CNT_W'(1);
            end
         end
         // Triggers during a pending delay are dropped, not queued
         if (hit && !st_q.done && !st_q.busy) begin
            if (st_q.skip_cnt < cfg_i.skip_first) begin
               st_d.skip_cnt = st_q.skip_cnt + 16'h0001;
            end else begin
               st_d.phase = (st_q.phase >= cfg_i.skip_factor) ? 16'h0000 :
                            st_q.phase + 16'h0001;
               if (st_q.phase == 16'h0000) begin
                  st_d.done = cfg_i.once;
                  if (dly_cyc == '0) begin
                     st_d.fire = 1'b1;
                  end else begin
                     st_d.busy = 1'b1;
                     st_d.dly  = dly_cyc;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign accept_o = st_q.fire;

endmodule : tsu_trig_qual
`default_nettype wire

/* tsu_pulse_gen.sv */
// Output pulse stretcher with width in microseconds
`timescale 1ns/1ps
`default_nettype none
module tsu_pulse_gen (
   input  wire logic        clk_i,     // 200 MHz clock
   input  wire logic        srst_i,    // Sync reset, active high
   input  wire logic        start_i,   // Start pulse
   input  wire logic [15:0] width_us_i,// Pulse width in microseconds
   output logic             pulse_o    // Registered output level
);
   typedef struct packed {
      logic                      out;
      logic [tsu_pkg::CNT_W-1:0] cnt;
   } tsu_pg_st_t;

   tsu_pg_st_t st_q;
   tsu_pg_st_t st_d;
   logic [tsu_pkg::CNT_W-1:0] w_cyc;

   assign w_cyc = tsu_pkg::CNT_W'(width_us_i) * tsu_pkg::CNT_W'(tsu_pkg::CYC_PER_US);

   always_comb begin
      st_d = st_q;
      if (start_i) begin
         // A zero width still gives a one-cycle pulse so no tick vanishes
         st_d.out = 1'b1;
         st_d.cnt = (w_cyc == '0) ? tsu_pkg::CNT_W'(1) : w_cyc;
      end else if (st_q.out) begin
         if (st_q.cnt <= tsu_pkg::CNT_W'(1)) begin
            st_d.out = 1'b0;
            st_d.cnt = '0;
         end else begin
            st_d.cnt = st_q.cnt - tsu_pkg::CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse_o = st_q.out;

endmodule : tsu_pulse_gen
`default_nettype wire

/* tsu_trig_src.sv */
// Behavioural external trigger source that drives the two input pins
`timescale 1ns/1ps
`default_nettype none
module tsu_trig_src (
   input  wire logic       clk_i,  // Bench clock
   input  wire logic       fire_i, // Start one pulse
   input  wire logic       sel_i,  // 0: first line, 1: second line
   output logic [1:0]      pins_o  // Pin levels
);
   int hi_cnt;
   initial begin
      pins_o = 2'h0;
      hi_cnt = 0;
   end
   // Pins move 1.3 ns after the edge, so they stay unrelated to sampling
   always @(posedge clk_i) begin
      if (fire_i) begin
         #1.3 pins_o[sel_i] = 1'b1;
         hi_cnt = 4;
      end else if (hi_cnt > 0) begin
         hi_cnt = hi_cnt - 1;
         if (hi_cnt == 0) #1.3 pins_o = 2'h0;
      end
   end
endmodule : tsu_trig_src
`default_nettype wire

/* tsu_top_properties.sv */
// Concurrent checks on the ports of the trigger synchronisation unit
`timescale 1ns/1ps
`default_nettype none
module tsu_top_chk #(
   parameter int unsigned SAMPLE_DIV = tsu_pkg::SAMPLE_DIV, // Cycles per sample
   parameter int unsigned REF_DIV    = tsu_pkg::REF_DIV     // Cycles per 1 Hz period
) (
   input wire logic                  clk_i,                 // Clock
   input wire logic                  srst_i,                // Sync reset
   input wire logic                  cfg_write_i,           // Config load
   input wire tsu_pkg::tsu_out_cfg_t out_cfg_i,             // Output config
   input wire logic                  trigger_output_line_o, // Output pin
   input wire logic                  sample_tick_o,         // Sample pulse
   input wire logic                  data_out_strobe_o,     // Record strobe
   input wire logic                  trigger_marker_flag_o, // Marker bit
   input wire tsu_pkg::tsu_msg_t     trigger_msg_o,         // Marker message
   input wire logic                  stream_active_o,       // Streaming level
   input wire logic [3:0]            cfg_reject_o           // Refused entries
);
   // ****************************************
   // High-time counter and checks
   // ****************************************
   logic [31:0] hi_q;
   logic [31:0] hi_d;
   always_comb begin
      hi_d = trigger_output_line_o ? hi_q + 32'h1 : 32'h0;
      if (cfg_write_i) hi_d = 32'h0;
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) hi_q <= 32'h0;
      else hi_q <= hi_d;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   chk_reset_values: assert property (disable iff (1'b0) srst_i |=>
      cfg_reject_o == 4'hf && stream_active_o && !trigger_output_line_o)
      else $error("reset values wrong");
   chk_tick_drives_out: assert property (sample_tick_o && !$past(cfg_write_i) &&
      out_cfg_i.mode == tsu_pkg::OUT_SAMPLE_TICK |=> trigger_output_line_o)
      else $error("output did not follow sample tick");
   chk_out_rise_cause: assert property ($rose(trigger_output_line_o) &&
      out_cfg_i.mode == tsu_pkg::OUT_SAMPLE_TICK |-> $past(sample_tick_o))
      else $error("output rose without a tick");
   chk_pulse_width: assert property ($fell(trigger_output_line_o) &&
      out_cfg_i.mode == tsu_pkg::OUT_REF_1HZ |->
      hi_q == 32'(out_cfg_i.pulse_us) * tsu_pkg::CYC_PER_US)
      else $error("output pulse width wrong");
   chk_msg_pulse: assert property (trigger_msg_o.valid |=> !trigger_msg_o.valid)
      else $error("message valid longer than one cycle");
   chk_msg_marker: assert property (trigger_msg_o.valid |-> trigger_marker_flag_o)
      else $error("message without marker");
   chk_marker_clear: assert property ($fell(trigger_marker_flag_o) |->
      $past(data_out_strobe_o))
      else $error("marker cleared without strobe");
   chk_reject_hold: assert property (!$past(cfg_write_i) |-> $stable(cfg_reject_o))
      else $error("refusal changed without config load");
   cov_msg: cover property (trigger_msg_o.valid);
   cov_stream: cover property ($rose(stream_active_o));
   cov_ref: cover property ($fell(trigger_output_line_o) &&
      out_cfg_i.mode == tsu_pkg::OUT_REF_1HZ);
endmodule : tsu_top_chk
`default_nettype wire

/* tb_tsu_top.sv */
// Self-checking testbench of the trigger synchronisation unit
`timescale 1ns/1ps
`default_nettype none
module tb_tsu_top;
   localparam int unsigned SDIV = 50;
   localparam int unsigned RDIV = 400;
   logic                  clk_i, srst_i, sw, cfg_wr, mode_q, fire, sel;
   logic [1:0]            pins;
   tsu_pkg::tsu_entry_t [3:0] cs;
   tsu_pkg::tsu_out_cfg_t oc;
   logic                  out_line, tick, strobe, marker, stream;
   tsu_pkg::tsu_msg_t     msg;
   logic [3:0]            rej;
   int                    err_count, checked, msg_n, strobe_n, cycles, n;
   logic [31:0]           stamp_l, stamp_d;
   tsu_top #(.SAMPLE_DIV(SDIV), .REF_DIV(RDIV)) dut (.clk_i(clk_i), .srst_i(srst_i),
      .trigger_input_line_i(pins), .software_request_line_i(sw), .cfg_write_i(cfg_wr),
      .trigger_config_set_i(cs), .out_cfg_i(oc), .meas_mode_enter_i(mode_q),
      .trigger_output_line_o(out_line), .sample_tick_o(tick), .data_out_strobe_o(strobe),
      .trigger_marker_flag_o(marker), .trigger_msg_o(msg), .stream_active_o(stream),
      .cfg_reject_o(rej));
   tsu_trig_src u_src (.clk_i(clk_i), .fire_i(fire), .sel_i(sel), .pins_o(pins));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Counting on the falling edge keeps it clear of the bench's own edge updates
   always @(negedge clk_i) begin
      cycles++;
      if (msg.valid === 1'b1) begin
         msg_n++;
         stamp_d = msg.stamp - stamp_l;
         stamp_l = msg.stamp;
      end
      if (strobe === 1'b1) strobe_n++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test();
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask : cyc
   function automatic tsu_pkg::tsu_entry_t ent(tsu_pkg::tsu_func_t f, tsu_pkg::tsu_line_t l,
      tsu_pkg::tsu_edge_t e, int sf, int sk, bit once, int dly);
      return '{1'b1, f, l, e, 16'(sf), 16'(sk), once, 1'b1, 16'(dly)};
   endfunction : ent
   task automatic load();
      cfg_wr <= 1'b1;
      cyc(1);
      cfg_wr <= 1'b0;
      cyc(3);
      msg_n = 0;
      strobe_n = 0;
   endtask : load
   task automatic shot(input bit line);
      fire <= 1'b1;
      sel  <= line;
      cyc(1);
      fire <= 1'b0;
      cyc(12);
   endtask : shot
   function automatic logic sg(bit w);
      return w ? out_line : tick;
   endfunction : sg
   task automatic gap(input bit w, output int k);
      k = 0;
      while (sg(w) !== 1'b1) @(negedge clk_i);
      while (sg(w) === 1'b1) begin @(negedge clk_i); k++; end
      while (sg(w) !== 1'b1) begin @(negedge clk_i); k++; end
   endtask : gap
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      srst_i = 1'b1; sw = 1'b0; cfg_wr = 1'b0; mode_q = 1'b0; fire = 1'b0; sel = 1'b0;
      cs = '0; oc = '{tsu_pkg::OUT_SAMPLE_TICK, 16'h0};
      err_count = 0; checked = 0; msg_n = 0; strobe_n = 0; cycles = 0;
      cyc(6);
      srst_i <= 1'b0;
      cyc(2);
      chk(32'(rej), 32'hf);
      chk(32'(stream), 32'h1);
      cs[0] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 2, 1, 0, 0);
      cs[1] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN2, tsu_pkg::EDGE_FALL, 0, 0, 0, 0);
      cs[2] <= ent(tsu_pkg::FN_LATEST, tsu_pkg::LINE_OUT, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      load();
      chk(32'(rej), 32'hc);
      repeat (7) shot(1'b0);
      chk(msg_n, 3);
      // Accepted shots are two shots of 13 cycles apart
      chk(stamp_d, 32'h1a);
      shot(1'b1);
      shot(1'b1);
      chk(msg_n, 5);
      gap(1'b0, n);
      chk(n, SDIV);
      cs[0] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 1, 0, 1, 0);
      cs[1] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN2, tsu_pkg::EDGE_BOTH, 0, 0, 0, 0);
      load();
      repeat (3) shot(1'b0);
      shot(1'b1);
      chk(msg_n, 3);
      mode_q <= 1'b1;
      cyc(1);
      mode_q <= 1'b0;
      cyc(3);
      msg_n = 0;
      repeat (3) shot(1'b0);
      chk(msg_n, 1);
      cs[0] <= ent(tsu_pkg::FN_LATEST, tsu_pkg::LINE_SW_REQ, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      cs[1] <= ent(tsu_pkg::FN_LATEST, tsu_pkg::LINE_IN2, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      cs[2] <= ent(tsu_pkg::FN_START, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      load();
      chk(32'(rej), 32'he);
      repeat (3) begin
         sw <= 1'b1;
         cyc(1);
         sw <= 1'b0;
         cyc(5);
      end
      shot(1'b1);
      chk(strobe_n, 3);
      cs[0] <= ent(tsu_pkg::FN_CLOCK_LOCK, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      cs[1] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      cs[2] <= ent(tsu_pkg::FN_MARK, tsu_pkg::LINE_IN2, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      load();
      chk(32'(rej), 32'hb);
      cs[0] <= ent(tsu_pkg::FN_CLOCK_LOCK, tsu_pkg::LINE_IN2, tsu_pkg::EDGE_RISE, 0, 0, 0, 0);
      cs[2] <= '0;
      load();
      chk(32'(rej), 32'hc);
      // Fire just after a natural tick, so an early tick can only come from the lock
      while (tick !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      fire <= 1'b1;
      sel  <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      n = 0;
      while (tick !== 1'b1 && n < 12) begin @(negedge clk_i); n++; end
      chk(32'(tick), 32'h1);
      cs[0] <= ent(tsu_pkg::FN_START, tsu_pkg::LINE_IN1, tsu_pkg::EDGE_RISE, 0, 0, 0, 1);
      cs[1] <= '0;
      cyc(1);
      load();
      chk(32'(stream), 32'h0);
      shot(1'b0);
      cyc(100);
      chk(strobe_n, 0);
      cyc(150);
      chk(32'(stream), 32'h1);
      chk(32'(strobe_n != 0), 32'h1);
      oc <= '{tsu_pkg::OUT_OFF, 16'h0};
      load();
      oc <= '{tsu_pkg::OUT_REF_1HZ, 16'h1};
      load();
      gap(1'b1, n);
      chk(n, RDIV);
      end_of_test();
   end
endmodule : tb_tsu_top
bind tsu_top tsu_top_chk #(.SAMPLE_DIV(SAMPLE_DIV), .REF_DIV(REF_DIV)) u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .cfg_write_i(cfg_write_i), .out_cfg_i(out_cfg_i),
   .trigger_output_line_o(trigger_output_line_o), .sample_tick_o(sample_tick_o),
   .data_out_strobe_o(data_out_strobe_o), .trigger_marker_flag_o(trigger_marker_flag_o),
   .trigger_msg_o(trigger_msg_o), .stream_active_o(stream_active_o),
   .cfg_reject_o(cfg_reject_o));
`default_nettype wire
